/* File: istb_pkg.sv */
// Package: register map, field layout and source numbering of the interrupt and time-base block
package istb_pkg;
	// Register word addresses (word index, one aligned word each)
	localparam logic [3:0] ADDR_CTRL0   = 4'h0; // global enable, edge selects, serial/ext flags+enables
	localparam logic [3:0] ADDR_CTRL1   = 4'h1; // periodic0, eeprom, converter, low-voltage
	localparam logic [3:0] ADDR_CTRL2   = 4'h2; // timer comparator flags+enables
	localparam logic [3:0] ADDR_CTRL3   = 4'h3; // uart transfer, periodic1
	localparam logic [3:0] ADDR_PSC     = 4'h4; // prescaler_clock_select
	localparam logic [3:0] ADDR_TB0     = 4'h5; // time_base0_control
	localparam logic [3:0] ADDR_TB1     = 4'h6; // time_base1_control
	localparam logic [3:0] ADDR_STATUS  = 4'h7; // service state, read only
	// Field positions in the time-base control registers
	localparam int TB_RUN_BIT    = 7;
	localparam int TB_PERIOD_LSB = 0;
	localparam int TB_PERIOD_W   = 3;
	localparam int TB_LOG2_BASE  = 8; // code 000 gives 2^8 prescaler clocks
	localparam int PSC_SEL_W     = 2;
	// Edge select codes, two bits per external pin
	localparam logic [1:0] EDGE_OFF  = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// Prescaler source codes
	localparam logic [1:0] PSC_SYS  = 2'h0;
	localparam logic [1:0] PSC_SYS4 = 2'h1;
	localparam int SYS_DIV = 4;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	// Source numbers, listed in fixed priority order, 0 highest
	localparam int SRC_EXT0  = 0;
	localparam int SRC_EXT1  = 1;
	localparam int SRC_SER   = 2;
	localparam int SRC_LV    = 3;
	localparam int SRC_ADC   = 4;
	localparam int SRC_EE    = 5;
	localparam int SRC_PTMP  = 6;
	localparam int SRC_PTMA  = 7;
	localparam int SRC_STMP  = 8;
	localparam int SRC_STMA  = 9;
	localparam int SRC_UART  = 10;
	localparam int SRC_TB0   = 11;
	localparam int SRC_TB1   = 12;
	localparam int NUM_SRC   = 13;
endpackage

/* File: istb_top.sv */
// Interrupt sources, priority, service handshake and two time bases, Avalon-MM slave
`timescale 1ns/10ps
// Behaviour
// R1: external pins trigger on rising, falling or both
// R2: edge select code can disable external request
// R3: serial flag set by SPI/I2C byte, match, timeout
// R4: serial flag set by UART events in UART mode
// R5: vector only with global, own enable, stack free
// R6: service clears source flag and global enable
// R7: service leaves UART status flags untouched
// R8: low-voltage flag set on low supply
// R9: converter flag set on conversion end
// R10: eeprom flag set on write cycle end
// R11: each timer has comparator A and P requests
// R12: uart transfer request pulsed, own enable
// R13: time-base flags set on divider overflow
// R14: prescaler source: sys, sys/4, subsidiary clock
// R15: time base 0: run bit 7, period 2^8..2^15
// R16: unimplemented control bits read as zero
// R17: time base 1 identical to time base 0
// R18: any flag rising edge wakes the device
// R19: return-from-interrupt sets global enable, plain return not
// R20: flags stay set until serviced or cleared
// R21: fixed priority, lowest source number first
module istb_top (
	// System
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// External interrupt pins, asynchronous
	input  wire logic [1:0]  ext_pin,
	// Subsidiary low-speed clock, asynchronous level
	input  wire logic        sub_clk,
	// Peripheral event pulses, same clock
	input  wire logic        ser_uart_mode,
	input  wire logic [2:0]  ser_spi_i2c_event,
	input  wire logic [5:0]  ser_uart_event,
	input  wire logic [5:0]  uart_event,
	input  wire logic        lv_detect,
	input  wire logic        adc_done,
	input  wire logic        ee_write_done,
	input  wire logic [1:0]  tm_match_p,
	input  wire logic [1:0]  tm_match_a,
	// Core handshake
	input  wire logic        stack_full,
	input  wire logic        int_ack,
	input  wire logic        ret_int,
	// Core outputs
	output logic             int_req,
	output logic [3:0]       int_vector,
	output logic             wake_up
);
	localparam int N = istb_pkg::NUM_SRC;

	// Elaboration guards: vector and register map fit this source list, divider and prescaler counter fit their parameters
	if (N > 16) begin : g_vec_fit
		$error("source count does not fit the four-bit vector");
	end
	if (istb_pkg::TB_LOG2_BASE + (1 << istb_pkg::TB_PERIOD_W) - 1 > 15) begin : g_div_fit
		$error("longest time-base period does not fit the divider");
	end
	if (N != 13) begin : g_map_fit
		$error("register map packs exactly thirteen sources");
	end
	if (istb_pkg::SYS_DIV != 4) begin : g_psc_fit
		$error("prescaler divider counter is two bits wide");
	end

	// Synchronisers for pins and subsidiary clock
	// Pins idle low, so zero reset values give no false edge after reset
	logic [2:0] sync1_reg, sync2_reg, sync3_reg;
	logic [2:0] sync1_next, sync2_next, sync3_next;
	always_comb begin
		sync1_next = {sub_clk, ext_pin};
		sync2_next = sync1_reg;
		sync3_next = sync2_reg; // Previous value, for edge detection
	end
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
			sync3_reg <= 3'h0;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			sync3_reg <= sync3_next;
		end
	end

	// Software state
	logic         gie_reg, gie_next;
	logic [N-1:0] flag_reg, flag_next;
	logic [N-1:0] en_reg, en_next;
	logic [3:0]   edge_reg, edge_next;
	logic [1:0]   psc_reg, psc_next;
	logic [7:0]   tb0_reg, tb0_next, tb1_reg, tb1_next;
	logic         wait_reg, wait_next;
	logic [31:0]  rdata_reg, rdata_next;
	logic         ireq_reg, ireq_next;
	logic [3:0]   ivec_reg, ivec_next;
	logic         wake_reg, wake_next;

	// External edge detection
	logic [1:0] ext_hit;
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			logic rise, fall;
			rise = sync2_reg[i] & ~sync3_reg[i];
			fall = ~sync2_reg[i] & sync3_reg[i];
			unique case (edge_reg[2*i +: 2])
				istb_pkg::EDGE_OFF:  ext_hit[i] = 1'b0; // see R2
				istb_pkg::EDGE_RISE: ext_hit[i] = rise; // see R1
				istb_pkg::EDGE_FALL: ext_hit[i] = fall;
				default:             ext_hit[i] = rise | fall;
			endcase
		end
	end

	// Prescaler clock enable: sys, sys/4, or subsidiary clock rising edge
	logic [1:0] div4_reg, div4_next;
	logic       psc_tick;
	always_comb begin
		div4_next = div4_reg + 2'h1;
		if (psc_reg == istb_pkg::PSC_SYS)
			psc_tick = 1'b1; // see R14
		else if (psc_reg == istb_pkg::PSC_SYS4)
			psc_tick = (div4_reg == 2'(istb_pkg::SYS_DIV - 1)); // see R14
		else
			psc_tick = sync2_reg[2] & ~sync3_reg[2]; // see R14
	end

	// Time-base dividers, one per time base
	// A stopped divider restarts from zero, so the first period is full length
	logic [14:0] tbc0_reg, tbc0_next, tbc1_reg, tbc1_next;
	logic        tb_ovf0, tb_ovf1;
	function automatic logic tb_over(input logic [14:0] cnt, input logic [7:0] ctl);
		logic [14:0] mask;
		mask = 15'((32'h1 << (istb_pkg::TB_LOG2_BASE
			+ int'(ctl[istb_pkg::TB_PERIOD_LSB +: istb_pkg::TB_PERIOD_W]))) - 1);
		return ((cnt & mask) == mask);
	endfunction
	always_comb begin
		tb_ovf0 = psc_tick & tb0_reg[istb_pkg::TB_RUN_BIT] & tb_over(tbc0_reg, tb0_reg); // see R15
		tb_ovf1 = psc_tick & tb1_reg[istb_pkg::TB_RUN_BIT] & tb_over(tbc1_reg, tb1_reg); // see R17
		tbc0_next = tb0_reg[istb_pkg::TB_RUN_BIT] ? tbc0_reg + (psc_tick ? 15'h1 : 15'h0) : 15'h0;
		tbc1_next = tb1_reg[istb_pkg::TB_RUN_BIT] ? tbc1_reg + (psc_tick ? 15'h1 : 15'h0) : 15'h0;
		if (tb_ovf0)
			tbc0_next = 15'h0;
		if (tb_ovf1)
			tbc1_next = 15'h0;
	end

	// Event vector, one bit per source
	// Peripherals pulse; a held level would set its flag again every cycle
	logic [N-1:0] evt;
	always_comb begin
		evt = '0;
		evt[istb_pkg::SRC_EXT0] = ext_hit[0];
		evt[istb_pkg::SRC_EXT1] = ext_hit[1];
		// UART status itself lives in the serial module; only the request is here
		evt[istb_pkg::SRC_SER]  = ser_uart_mode ? |ser_uart_event : |ser_spi_i2c_event; // see R3, R4
		evt[istb_pkg::SRC_LV]   = lv_detect;      // see R8
		evt[istb_pkg::SRC_ADC]  = adc_done;       // see R9
		evt[istb_pkg::SRC_EE]   = ee_write_done;  // see R10
		evt[istb_pkg::SRC_PTMP] = tm_match_p[0];  // see R11
		evt[istb_pkg::SRC_PTMA] = tm_match_a[0];
		evt[istb_pkg::SRC_STMP] = tm_match_p[1];
		evt[istb_pkg::SRC_STMA] = tm_match_a[1];
		evt[istb_pkg::SRC_UART] = |uart_event;    // see R12
		evt[istb_pkg::SRC_TB0]  = tb_ovf0;        // see R13
		evt[istb_pkg::SRC_TB1]  = tb_ovf1;        // see R13
	end

	// Priority pick among pending enabled sources
	// Walking down from the last source leaves the lowest pending number
	logic [N-1:0] pend;
	logic         any_pend;
	logic [3:0]   pick;
	always_comb begin
		pend = flag_reg & en_reg;
		any_pend = gie_reg & ~stack_full & (|pend); // see R5
		pick = 4'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (pend[i])
				pick = 4'(i); // see R21
		end
	end

	// Register map: flag and enable fields per control word
	function automatic logic [7:0] pack4(input logic [3:0] f, input logic [3:0] e);
		return {f, e};
	endfunction
	logic acc;
	logic wr;
	always_comb begin
		acc = (avs_read | avs_write) & wait_reg;
		// A write lands at the answer edge, where the master samples waitrequest low
		wr  = avs_write & ~wait_reg;
	end

	// Flag, enable and control updates
	always_comb begin
		logic [N-1:0] sw_clr, sw_set, svc_clr;
		logic [7:0]   wd;
		wd = avs_writedata[7:0];
		sw_clr = '0;
		sw_set = '0;
		svc_clr = '0;
		gie_next = gie_reg;
		en_next = en_reg;
		edge_next = edge_reg;
		psc_next = psc_reg;
		tb0_next = tb0_reg;
		tb1_next = tb1_reg;
		if (wr) begin
			unique case (avs_address)
				istb_pkg::ADDR_CTRL0: begin
					gie_next = wd[0];
					en_next[2:0] = {wd[3], wd[2], wd[1]};
					sw_set[2:0] = {wd[6], wd[5], wd[4]};
					sw_clr[2:0] = ~{wd[6], wd[5], wd[4]};
					edge_next = avs_writedata[11:8];
				end
				istb_pkg::ADDR_CTRL1: begin
					en_next[5:3] = wd[2:0];
					en_next[istb_pkg::SRC_TB0] = wd[3];
					sw_set[5:3] = wd[6:4];
					sw_clr[5:3] = ~wd[6:4];
					sw_set[istb_pkg::SRC_TB0] = wd[7];
					sw_clr[istb_pkg::SRC_TB0] = ~wd[7];
				end
				istb_pkg::ADDR_CTRL2: begin
					en_next[9:6] = wd[3:0];
					sw_set[9:6] = wd[7:4];
					sw_clr[9:6] = ~wd[7:4];
				end
				istb_pkg::ADDR_CTRL3: begin
					en_next[istb_pkg::SRC_TB1] = wd[0];
					en_next[istb_pkg::SRC_UART] = wd[1];
					sw_set[istb_pkg::SRC_TB1] = wd[4];
					sw_clr[istb_pkg::SRC_TB1] = ~wd[4];
					sw_set[istb_pkg::SRC_UART] = wd[5];
					sw_clr[istb_pkg::SRC_UART] = ~wd[5];
				end
				istb_pkg::ADDR_PSC: psc_next = wd[istb_pkg::PSC_SEL_W-1:0];
				istb_pkg::ADDR_TB0: tb0_next = wd & 8'h87; // see R15, R16
				istb_pkg::ADDR_TB1: tb1_next = wd & 8'h87; // see R17, R16
				default: ;
			endcase
		end
		// Service by the core: clear chosen flag and global enable
		// A return in the same cycle as a service is dropped: the service wins
		if (int_ack && ireq_reg) begin
			svc_clr[ivec_reg] = 1'b1; // see R6, R7
			gie_next = 1'b0;          // see R6
		end else if (ret_int) begin
			gie_next = 1'b1;          // see R19
		end
		// Flags hold until cleared; a new event beats any clear
		flag_next = ((flag_reg & ~sw_clr & ~svc_clr) | sw_set | evt); // see R20
	end

	// Core request, vector, wake and bus answer
	// The bus answers after exactly one wait cycle, never more
	always_comb begin
		ireq_next = any_pend & ~(int_ack & ireq_reg);
		ivec_next = pick;
		wake_next = |(flag_next & ~flag_reg); // see R18
		wait_next = ~acc; // One wait cycle, then answer
		rdata_next = 32'h0;
		if (avs_read && wait_reg) begin
			unique case (avs_address)
				istb_pkg::ADDR_CTRL0: rdata_next = {20'h0, edge_reg,
					1'b0, flag_reg[2:0], en_reg[2:0], gie_reg};
				istb_pkg::ADDR_CTRL1: rdata_next = {24'h0,
					flag_reg[istb_pkg::SRC_TB0], flag_reg[5:3],
					en_reg[istb_pkg::SRC_TB0], en_reg[5:3]};
				istb_pkg::ADDR_CTRL2: rdata_next = {24'h0, pack4(flag_reg[9:6], en_reg[9:6])};
				istb_pkg::ADDR_CTRL3: rdata_next = {24'h0, 2'h0,
					flag_reg[istb_pkg::SRC_UART], flag_reg[istb_pkg::SRC_TB1], 2'h0,
					en_reg[istb_pkg::SRC_UART], en_reg[istb_pkg::SRC_TB1]};
				istb_pkg::ADDR_PSC: rdata_next = {30'h0, psc_reg}; // see R16
				istb_pkg::ADDR_TB0: rdata_next = {24'h0, tb0_reg};
				istb_pkg::ADDR_TB1: rdata_next = {24'h0, tb1_reg};
				istb_pkg::ADDR_STATUS: rdata_next = {23'h0, ireq_reg, ivec_reg,
					any_pend, stack_full, 1'b0, gie_reg};
				default: rdata_next = 32'h0;
			endcase
		end
	end

	// State registers
	// Waitrequest leaves reset high, so no request is answered during reset
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			gie_reg   <= 1'b0;
			flag_reg  <= '0;
			en_reg    <= '0;
			edge_reg  <= 4'h0;
			psc_reg   <= 2'h0;
			tb0_reg   <= istb_pkg::RST_BYTE;
			tb1_reg   <= istb_pkg::RST_BYTE;
			div4_reg  <= 2'h0;
			tbc0_reg  <= 15'h0;
			tbc1_reg  <= 15'h0;
			wait_reg  <= 1'b1;
			rdata_reg <= 32'h0;
			ireq_reg  <= 1'b0;
			ivec_reg  <= 4'h0;
			wake_reg  <= 1'b0;
		end else begin
			gie_reg   <= gie_next;
			flag_reg  <= flag_next;
			en_reg    <= en_next;
			edge_reg  <= edge_next;
			psc_reg   <= psc_next;
			tb0_reg   <= tb0_next;
			tb1_reg   <= tb1_next;
			div4_reg  <= div4_next;
			tbc0_reg  <= tbc0_next;
			tbc1_reg  <= tbc1_next;
			wait_reg  <= wait_next;
			rdata_reg <= rdata_next;
			ireq_reg  <= ireq_next;
			ivec_reg  <= ivec_next;
			wake_reg  <= wake_next;
		end
	end

	// Outputs straight from flip-flops
	// No combinational path from the bus or the core reaches an output
	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign int_req         = ireq_reg;
	assign int_vector      = ivec_reg;
	assign wake_up         = wake_reg;
endmodule

/* File: istb_checker.sv */
// Bound port assertions for the interrupt and time-base block
`timescale 1ns/10ps
module istb_checker (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        reset,
	// Register bus
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Core side
	input wire logic        stack_full,
	input wire logic        int_ack,
	input wire logic        int_req,
	input wire logic [3:0]  int_vector,
	input wire logic        wake_up
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Bus answers after exactly one cycle, and only for one cycle
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer missing");
	a_bus_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("bus answer too long");
	a_rdata_idle: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
		else $error("read data outside answer");
	// Service handshake; a full stack holds every request back
	a_ack_clears: assert property (int_ack && int_req |=> !int_req)
		else $error("request kept after service");
	a_stack_blocks: assert property (stack_full |=> !int_req)
		else $error("request with full stack");
	a_req_rise: assert property ($rose(int_req) |-> !$past(stack_full))
		else $error("request rose after full stack");
	a_vec_range: assert property (int_req |-> int_vector < 4'hd)
		else $error("vector out of range");
	// A request only drops through service, a full stack or a register write
	a_req_drop: assert property ($fell(int_req) |-> $past(int_ack) || $past(stack_full) ||
		$past(avs_write) || $past(avs_write, 2)) else $error("request dropped alone");
	c_service: cover property (int_ack && int_req);
	c_wake: cover property (wake_up);
	c_last_src: cover property (int_req && int_vector == 4'hc);
endmodule
bind istb_top istb_checker i_istb_checker (.clk_sys, .reset, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .stack_full, .int_ack, .int_req, .int_vector, .wake_up);

/* File: istb_core_model.sv */
// Core-side model: takes requests, returns later, holds the stack full on command
`timescale 1ns/10ps
module istb_core_model (
	// Clock and bench control
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic       ack_on,
	input  wire logic       ret_on,
	input  wire logic       stack_hold,
	// Block side
	input  wire logic       int_req,
	input  wire logic [3:0] int_vector,
	output logic            int_ack,
	output logic            ret_int,
	output logic            stack_full,
	// Service seen by the bench
	output logic            taken,
	output logic [3:0]      taken_vec
);
	logic [2:0] wait_cnt;
	// One ack pulse per call; no new call until the routine has run
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			{int_ack, ret_int, stack_full, taken, taken_vec, wait_cnt} <= '0;
		end else begin
			stack_full <= stack_hold;
			int_ack <= ack_on && int_req && !int_ack && wait_cnt == 3'h0;
			taken <= int_ack && int_req;
			taken_vec <= int_vector;
			wait_cnt <= (int_ack && int_req) ? 3'h5 : wait_cnt - 3'(wait_cnt != 3'h0);
			ret_int <= ret_on && wait_cnt == 3'h1;
		end
	end
endmodule

/* File: testbench.sv */
// Self-checking bench for the interrupt and time-base block
`timescale 1ns/10ps
module testbench;
	logic        clk_sys, reset = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
	logic [3:0]  avs_address = 4'h0, int_vector, taken_vec;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, evs = 32'h0, d;
	logic [1:0]  ext_pin = 2'h0, tm_match_p, tm_match_a;
	logic [5:0]  ser_uart_event, uart_event;
	logic [2:0]  ser_spi_i2c_event;
	logic        sub_clk = 0, ser_uart_mode = 0, lv_detect, adc_done, ee_write_done;
	logic        stack_full, int_ack, ret_int, int_req, wake_up, taken;
	logic        ack_on = 0, ret_on = 0, stack_hold = 0;
	logic [31:0] exp_rd[$];
	logic [3:0]  exp_vec[$];
	int          err_count = 0, n_compared = 0, n_wake = 0, a, e;
	// One-hot event word fans out to every peripheral pulse
	assign {tm_match_a, tm_match_p, ee_write_done, adc_done, lv_detect, uart_event,
		ser_uart_event, ser_spi_i2c_event} = evs[21:0];
	istb_top i_istb_top (.clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .ext_pin, .sub_clk, .ser_uart_mode, .ser_spi_i2c_event,
		.ser_uart_event, .uart_event, .lv_detect, .adc_done, .ee_write_done, .tm_match_p,
		.tm_match_a, .stack_full, .int_ack, .ret_int, .int_req, .int_vector, .wake_up);
	istb_core_model i_istb_core_model (.clk_sys, .reset, .ack_on, .ret_on, .stack_hold,
		.int_req, .int_vector, .int_ack, .ret_int, .stack_full, .taken, .taken_vec);
	// Clocks: the slow one is 1/8 of the system rate
	initial begin
		clk_sys = 0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial forever begin
		repeat (4) @(posedge clk_sys);
		sub_clk <= ~sub_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Held until waitrequest is sampled low at a rising edge; one idle cycle after
	task automatic bus(input logic w, input int ad, input logic [31:0] wd);
		avs_address <= 4'(ad);
		avs_writedata <= wd;
		avs_read <= !w;
		avs_write <= w;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		avs_read <= 0;
		avs_write <= 0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input int ad, input int ex);
		exp_rd.push_back(32'(ex));
		bus(0, ad, 32'h0);
	endtask
	task automatic ev(input int b);
		evs <= 32'h1 << b;
		@(posedge clk_sys);
		evs <= 32'h0;
		@(posedge clk_sys);
	endtask
	// Results are taken at the rising edge where they stand, before it updates them
	always @(posedge clk_sys) begin
		if (avs_read && avs_waitrequest === 1'b0) chk(avs_readdata, exp_rd.pop_front());
		if (taken === 1'b1) chk({28'h0, taken_vec}, {28'h0, exp_vec.pop_front()});
		if (wake_up === 1'b1) n_wake++;
	end
	task automatic give_verdict;
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// A hang is cut short well past the expected run length
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		give_verdict();
	end
	initial begin
		void'($urandom(32'he01f));
		repeat (6) @(posedge clk_sys);
		reset <= 0;
		@(posedge clk_sys);
		for (int i = 0; i < 9; i++) rd(i, 0);
		for (int i = 4; i < 7; i++) begin
			bus(1, i, 32'hff);
			rd(i, i == 4 ? 32'h3 : 32'h87);
			bus(1, i, 32'h0);
		end
		d = $urandom;
		bus(1, 2, d);
		rd(2, d & 32'hff);
		bus(1, 2, 32'h0);
		$display("Register test done");
		n_wake = 0;
		for (int b = 0; b < 22; b++) begin
			ser_uart_mode <= b > 2 && b < 9;
			ev(b);
			if (b < 9) {a, e} = {32'd0, 32'h40};
			else if (b < 15) {a, e} = {32'd3, 32'h20};
			else if (b < 18) {a, e} = {32'd1, 32'h10 << (b - 15)};
			else {a, e} = {32'd2, 32'h10 << ((b - 18) / 2 + 2 * ((b - 18) % 2))};
			rd(a, e);
			bus(1, a, 32'h0);
		end
		chk(n_wake, 22);
		$display("Event test done");
		for (int c = 0; c < 4; c++) begin
			bus(1, 0, c * 32'h500);
			ext_pin <= 2'h3;
			repeat (6) @(posedge clk_sys);
			rd(0, c * 32'h500 + (c % 2) * 32'h30);
			bus(1, 0, c * 32'h500);
			ext_pin <= 2'h0;
			repeat (6) @(posedge clk_sys);
			rd(0, c * 32'h500 + (c / 2) * 32'h30);
		end
		$display("Edge test done");
		ack_on <= 1;
		ret_on <= 1;
		bus(1, 1, 32'hff);
		bus(1, 2, 32'hff);
		bus(1, 3, 32'h33);
		for (int v = 0; v < 13; v++) exp_vec.push_back(4'(v));
		bus(1, 0, 32'h7f);
		repeat (200) @(posedge clk_sys);
		rd(1, 32'h0f);
		$display("Priority test done");
		stack_hold <= 1;
		repeat (2) @(posedge clk_sys);
		ev(16);
		repeat (20) @(posedge clk_sys);
		exp_vec.push_back(4'h4);
		stack_hold <= 0;
		ret_on <= 0;
		repeat (20) @(posedge clk_sys);
		ev(15);
		repeat (20) @(posedge clk_sys);
		rd(1, 32'h1f);
		$display("Stack test done");
		bus(1, 1, 32'h0);
		bus(1, 5, 32'h80);
		repeat (300) @(posedge clk_sys);
		rd(1, 32'h80);
		bus(1, 5, 32'h0);
		for (int s = 1; s < 3; s++) begin
			bus(1, 3, 32'h0);
			bus(1, 4, s);
			bus(1, 6, 32'h80 + 2 - s);
			repeat (2200) @(posedge clk_sys);
			rd(3, 32'h10);
			bus(1, 6, 32'h0);
		end
		$display("Time base test done");
		chk(exp_vec.size(), 0);
		give_verdict();
	end
endmodule
